// file: src/pdp_consts.svh
/*
 * Constants of the synthesizer program interface: register offsets,
 * field positions, reset values and filter limits.
 * Assumes inclusion by bare name from the top module.
 */
// How it works
// - compat pin low zeroes upper M, R bits
// - compat pin high: upper bits via bus/serial
// - feedback output is oscillator divided by ratio
// - reference output is reference divided by ratio
// - pump up pulses when feedback lags
// - pump down pulses when feedback leads
// - lock pin released locked, driven low unlocked
// - OR of pumps filtered, compared for lock
// - first main strobe latches eight bits
// - second main strobe latches R5:4, M8:7
// - swallow strobe latches R3:0 and A3:0
// - bus mode transfer strobe copies primary over
// - bus bank select: 1 primary, 0 secondary
// - shift one bit per shift clock rise while shift enable is low
// - shift enable rise moves serial data to secondary
// - serial transfer strobe copies primary to secondary
// - serial bank select: 1 primary, 0 secondary
// - direct mode takes counts straight from pins
// - prescaler active while its enable is low
`ifndef PDP_CONSTS_SVH
`define PDP_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PDP_REG_LOCK_CFG 8'h00
`define PDP_REG_STATUS 8'h04
`define PDP_REG_ACTIVE 8'h08
`define PDP_REG_PRIMARY 8'h0C
`define PDP_REG_SECONDARY 8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PDP_CFG_THR_LSB 0
`define PDP_CFG_STEP_LSB 8
`define PDP_ST_MODE_LSB 0
`define PDP_ST_LOCKED 2
`define PDP_ST_COMPAT 3
`define PDP_ST_BANK 4
`define PDP_CNT_BITS 20

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define PDP_CNT_RST 20'h00000
`define PDP_THR_RST 8'h40
`define PDP_STEP_RST 8'h10
`define PDP_LF_MAX 8'hFF
`define PDP_MUL_TEN 13'h000A

`endif

// file: src/pdp_pkg.sv
/*
 * Types of the synthesizer program interface.
 * Assumes the constants header sits beside it.
 */
package pdp_pkg;

    // gray along bus, serial, direct
    typedef enum logic [1:0] {
        PDP_MODE_BUS = 2'b00,
        PDP_MODE_SERIAL = 2'b01,
        PDP_MODE_DIRECT = 2'b11
    } pdp_mode_e;

    typedef struct packed {
        logic pre_n;
        logic [8:0] m;
        logic [5:0] r;
        logic [3:0] a;
    } pdp_cnt_s;

endpackage

// file: src/pdp_div_if.sv
/*
 * Carrier between the top and a divider: ratio in, divided level and
 * wrap tick out.
 * Assumes one divider per instance, all on clk_i.
 */
`timescale 1ns/1ns
interface pdp_div_if #(parameter int W = 13);
    logic [W-1:0] ratio;
    logic div_out;
    logic tick;
    modport ctrl (output ratio, input div_out, input tick);
    modport div (input ratio, output div_out, output tick);
endinterface

// file: src/pdp_divider.sv
/*
 * Programmable divider counting rising edges of a sampled input.
 * Assumes edge_i and in_level_i are already synchronised to clk_i.
 */
`timescale 1ns/1ns
module pdp_divider #(
    parameter int W = 13
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic in_level_i,
    input wire logic edge_i,
    pdp_div_if.div dv
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic wrap;

    // ----------------------------------------------------------------
    // count and output
    // ----------------------------------------------------------------
    always_comb begin
        wrap = edge_i && (count >= dv.ratio - W'(1));
        if (!edge_i) begin
            next_count = count;
        end else if (wrap) begin
            next_count = '0;
        end else begin
            next_count = count + W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= '0;
            dv.tick <= 1'b0;
            dv.div_out <= 1'b0;
        end else if (ce_i) begin
            count <= next_count;
            dv.tick <= wrap;
            if (dv.ratio == W'(1)) begin
                dv.div_out <= in_level_i;
            end else begin
                dv.div_out <= (next_count < (dv.ratio >> 1));
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [W-1:0] edges_seen;
    logic period_synced;
    // first period after a ratio change is partial, so skip it
    always_ff @(posedge clk_i) begin
        if (rst_i || !$stable(dv.ratio)) begin
            edges_seen <= '0;
            period_synced <= 1'b0;
        end else if (ce_i && edge_i) begin
            edges_seen <= wrap ? '0 : edges_seen + W'(1);
            period_synced <= period_synced | wrap;
        end
    end

    div_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wrap && $stable(dv.ratio) && period_synced && edges_seen != '0
            |-> edges_seen == dv.ratio - W'(1))
        else $error("divider wrapped after wrong edge count");

endmodule // pdp_divider

// file: src/pdp_top.sv
/*
 * Program interface and digital core of the synthesizer: three load
 * modes, primary and secondary banks, dividers, phase detector, lock.
 * Assumes pins asynchronous to clk_i and a classic Wishbone master.
 */
`timescale 1ns/1ns
`include "pdp_consts.svh"
module pdp_top #(
    parameter int VCO_W = 13,
    parameter int REF_W = 7,
    parameter int LF_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic legacy_compat_select_n_i,
    input wire logic bus_select_n_i,
    input wire logic serial_select_i,
    input wire logic [7:0] host_data_bus_i,
    input wire logic main_low_write_strobe_i,
    input wire logic main_high_write_strobe_i,
    input wire logic swallow_write_strobe_i,
    input wire logic transfer_write_strobe_i,
    input wire logic bus_bank_select_i,
    input wire logic serial_bank_select_i,
    input wire logic shift_data_in_i,
    input wire logic shift_enable_n_i,
    input wire logic shift_clk_i,
    input wire logic [3:0] direct_swallow_i,
    input wire logic [3:0] direct_ref_i,
    input wire logic oscillator_input_i,
    input wire logic reference_input_i,
    output logic feedback_divided_out_o,
    output logic reference_divided_out_o,
    output logic pump_up_pulse_o,
    output logic pump_down_pulse_o,
    output logic lock_filter_node_o,
    output logic lock_indicator_o,
    output logic lock_indicator_oe_o
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    localparam int NPIN = 30;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s1;
    logic [NPIN-1:0] pin_s2;
    logic compat_n_s, bus_n_s, serial_s;
    logic [7:0] data_s;
    logic m1_s, m2_s, sw_s, tr_s, bbank_s, sbank_s, shift_data_in_s, sen_n_s, sclk_s;
    logic [3:0] dir_sw_s;
    logic [3:0] dir_ref_s;
    logic osc_s, refin_s;

    assign pin_raw = {legacy_compat_select_n_i, bus_select_n_i, serial_select_i,
        host_data_bus_i, main_low_write_strobe_i, main_high_write_strobe_i,
        swallow_write_strobe_i, transfer_write_strobe_i, bus_bank_select_i,
        serial_bank_select_i, shift_data_in_i, shift_enable_n_i, shift_clk_i,
        direct_swallow_i, direct_ref_i, oscillator_input_i, reference_input_i};

    // keeps sampling through reset so no stale level makes a false edge
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
        end
    end

    assign {compat_n_s, bus_n_s, serial_s, data_s, m1_s, m2_s, sw_s, tr_s, bbank_s,
        sbank_s, shift_data_in_s, sen_n_s, sclk_s, dir_sw_s, dir_ref_s, osc_s, refin_s} = pin_s2;

    // ----------------------------------------------------------------
    // edge finders
    // ----------------------------------------------------------------
    logic [7:0] edge_cur;
    logic [7:0] edge_prev;
    logic [7:0] edge_rise;
    logic m1_r, m2_r, sw_r, tr_r, sen_r, sclk_r, osc_r, refin_r;

    assign edge_cur = {m1_s, m2_s, sw_s, tr_s, sen_n_s, sclk_s, osc_s, refin_s};
    assign edge_rise = edge_cur & ~edge_prev;
    assign {m1_r, m2_r, sw_r, tr_r, sen_r, sclk_r, osc_r, refin_r} = edge_rise;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_prev <= 8'hFF;
        end else if (ce_i) begin
            edge_prev <= edge_cur;
        end
    end

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    function automatic pdp_pkg::pdp_mode_e decode_mode(input logic bus_n,
                                                       input logic ser);
        if (bus_n) begin
            decode_mode = pdp_pkg::PDP_MODE_DIRECT;
        end else if (ser) begin
            decode_mode = pdp_pkg::PDP_MODE_SERIAL;
        end else begin
            decode_mode = pdp_pkg::PDP_MODE_BUS;
        end
    endfunction

    pdp_pkg::pdp_mode_e mode;
    assign mode = decode_mode(bus_n_s, serial_s);

    logic in_bus, in_serial;
    assign in_bus = (mode == pdp_pkg::PDP_MODE_BUS);
    assign in_serial = (mode == pdp_pkg::PDP_MODE_SERIAL);

    // ----------------------------------------------------------------
    // serial shift register
    // ----------------------------------------------------------------
    logic [`PDP_CNT_BITS-1:0] shreg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shreg <= `PDP_CNT_RST;
        end else if (ce_i && in_serial && sclk_r && !sen_n_s) begin
            shreg <= {shreg[`PDP_CNT_BITS-2:0], shift_data_in_s};
        end
    end

    // ----------------------------------------------------------------
    // primary bank
    // ----------------------------------------------------------------
    pdp_pkg::pdp_cnt_s prim;
    pdp_pkg::pdp_cnt_s sec;
    pdp_pkg::pdp_cnt_s next_prim;

    always_comb begin
        next_prim = prim;
        if (in_bus) begin
            if (m1_r) begin
                next_prim.pre_n = data_s[7];
                next_prim.m[6:0] = data_s[6:0];
            end
            if (m2_r) begin
                next_prim.r[5:4] = data_s[3:2];
                next_prim.m[8:7] = data_s[1:0];
            end
            if (sw_r) begin
                next_prim.r[3:0] = data_s[7:4];
                next_prim.a = data_s[3:0];
            end
        end else if (in_serial && sen_r) begin
            next_prim = pdp_pkg::pdp_cnt_s'(shreg);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prim <= pdp_pkg::pdp_cnt_s'(`PDP_CNT_RST);
        end else if (ce_i) begin
            prim <= next_prim;
        end
    end

    // ----------------------------------------------------------------
    // secondary bank
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sec <= pdp_pkg::pdp_cnt_s'(`PDP_CNT_RST);
        end else if (ce_i) begin
            if (in_bus && tr_r) begin
                sec <= prim;
            end else if (in_serial && (sen_r || tr_r)) begin
                sec <= next_prim;
            end
        end
    end

    // ----------------------------------------------------------------
    // active counts
    // ----------------------------------------------------------------
    pdp_pkg::pdp_cnt_s act;
    logic bank_primary;

    always_comb begin
        bank_primary = 1'b0;
        unique case (mode)
            pdp_pkg::PDP_MODE_BUS: begin
                bank_primary = bbank_s;
                act = bbank_s ? prim : sec;
            end
            pdp_pkg::PDP_MODE_SERIAL: begin
                bank_primary = sbank_s;
                act = sbank_s ? prim : sec;
            end
            pdp_pkg::PDP_MODE_DIRECT: begin
                act.pre_n = data_s[7];
                act.m = {2'b00, data_s[6:0]};
                act.a = dir_sw_s;
                act.r = {2'b00, dir_ref_s};
            end
            default: begin
                act = sec;
            end
        endcase
        if (!compat_n_s) begin
            act.m[8:7] = 2'b00;
            act.r[5:4] = 2'b00;
        end
    end

    // ----------------------------------------------------------------
    // ratios and dividers
    // ----------------------------------------------------------------
    logic [VCO_W-1:0] m_plus;
    assign m_plus = VCO_W'(act.m) + VCO_W'(1);

    pdp_div_if #(.W(VCO_W)) vco_if ();
    pdp_div_if #(.W(REF_W)) ref_if ();

    // dual modulus 10/11 gives 10*(M+1)+A; bypassed gives M+1
    assign vco_if.ratio = act.pre_n ? m_plus
        : VCO_W'(m_plus * VCO_W'(`PDP_MUL_TEN)) + VCO_W'(act.a);
    assign ref_if.ratio = REF_W'(act.r) + REF_W'(1);

    pdp_divider #(.W(VCO_W)) u_feedback_divided_out (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .in_level_i(osc_s),
        .edge_i(osc_r),
        .dv(vco_if.div)
    );

    pdp_divider #(.W(REF_W)) u_ref_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .in_level_i(refin_s),
        .edge_i(refin_r),
        .dv(ref_if.div)
    );

    assign feedback_divided_out_o = vco_if.div_out;
    assign reference_divided_out_o = ref_if.div_out;

    // ----------------------------------------------------------------
    // phase detector
    // ----------------------------------------------------------------
    logic next_up, next_dn;
    always_comb begin
        next_up = pump_up_pulse_o | ref_if.tick;
        next_dn = pump_down_pulse_o | vco_if.tick;
        if (next_up && next_dn) begin
            next_up = 1'b0;
            next_dn = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pump_up_pulse_o <= 1'b0;
            pump_down_pulse_o <= 1'b0;
        end else if (ce_i) begin
            pump_up_pulse_o <= next_up;
            pump_down_pulse_o <= next_dn;
        end
    end

    // ----------------------------------------------------------------
    // lock filter and registers
    // ----------------------------------------------------------------
    logic [7:0] lock_thr;
    logic [7:0] lock_step;
    logic [LF_W-1:0] lf;
    logic [LF_W:0] lf_sum;
    logic locked;

    assign lock_filter_node_o = pump_up_pulse_o | pump_down_pulse_o;
    assign lf_sum = {1'b0, lf} + (LF_W+1)'(lock_step);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lf <= LF_W'(`PDP_LF_MAX);
            locked <= 1'b0;
        end else if (ce_i) begin
            if (lock_filter_node_o) begin
                lf <= lf_sum[LF_W] ? LF_W'(`PDP_LF_MAX) : lf_sum[LF_W-1:0];
            end else if (lf != '0) begin
                lf <= lf - LF_W'(1);
            end
            locked <= (lf < LF_W'(lock_thr));
        end
    end

    assign lock_indicator_o = 1'b0;
    assign lock_indicator_oe_o = !locked;

    logic req;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_thr <= `PDP_THR_RST;
            lock_step <= `PDP_STEP_RST;
        end else if (ce_i && req && wb_we_i && wb_adr_i == `PDP_REG_LOCK_CFG) begin
            if (wb_sel_i[0]) begin
                lock_thr <= wb_dat_i[`PDP_CFG_THR_LSB +: 8];
            end
            if (wb_sel_i[1]) begin
                lock_step <= wb_dat_i[`PDP_CFG_STEP_LSB +: 8];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce_i) begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h00000000;
            if (req && !wb_we_i) begin
                unique case (wb_adr_i)
                    `PDP_REG_LOCK_CFG: wb_dat_o <= {16'h0000, lock_step, lock_thr};
                    `PDP_REG_STATUS: wb_dat_o <= {27'h0000000, bank_primary,
                        compat_n_s, locked, mode};
                    `PDP_REG_ACTIVE: wb_dat_o <= {12'h000, act};
                    `PDP_REG_PRIMARY: wb_dat_o <= {12'h000, prim};
                    `PDP_REG_SECONDARY: wb_dat_o <= {12'h000, sec};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    compat_zero_a: assert property (!compat_n_s |->
        act.m[8:7] == 2'b00 && act.r[5:4] == 2'b00)
        else $error("upper count bits not forced low");
    compat_prog_a: assert property (compat_n_s && in_bus && bbank_s |->
        act == prim)
        else $error("upper bits not programmable in bus mode");
    main_low_a: assert property (ce_i && in_bus && m1_r |=>
        prim.pre_n == $past(data_s[7]) && prim.m[6:0] == $past(data_s[6:0]))
        else $error("first main write not captured");
    main_high_a: assert property (ce_i && in_bus && m2_r |=>
        {prim.r[5:4], prim.m[8:7]} == $past(data_s[3:0]))
        else $error("second main write not captured");
    swallow_wr_a: assert property (ce_i && in_bus && sw_r |=>
        {prim.r[3:0], prim.a} == $past(data_s))
        else $error("swallow write not captured");
    hop_copy_a: assert property (ce_i && in_bus && tr_r |=> sec == $past(prim))
        else $error("transfer strobe did not copy primary");
    shift_in_a: assert property (ce_i && in_serial && sclk_r && !sen_n_s |=>
        shreg == {$past(shreg[`PDP_CNT_BITS-2:0]), $past(shift_data_in_s)})
        else $error("serial bit not shifted");
    sen_xfer_a: assert property (ce_i && in_serial && sen_r |=>
        sec == $past(shreg) && prim == $past(shreg))
        else $error("shift enable rise did not transfer");
    serial_hop_a: assert property (ce_i && in_serial && tr_r && !sen_r |=>
        sec == $past(prim))
        else $error("serial transfer strobe did not copy");
    serial_bank_a: assert property (in_serial |->
        (sbank_s ? act == prim : act == sec) || !compat_n_s)
        else $error("serial bank select ignored");
    direct_pins_a: assert property (mode == pdp_pkg::PDP_MODE_DIRECT |->
        act.m == {2'b00, data_s[6:0]} && act.a == dir_sw_s && act.r == {2'b00, dir_ref_s})
        else $error("direct mode counts differ from pins");
    presc_ratio_a: assert property (!act.pre_n |->
        vco_if.ratio == VCO_W'(m_plus * VCO_W'(`PDP_MUL_TEN)) + VCO_W'(act.a))
        else $error("prescaler ratio wrong");
    pfd_up_a: assert property (ce_i && ref_if.tick && !vco_if.tick && !pump_down_pulse_o
        |=> pump_up_pulse_o && !pump_down_pulse_o)
        else $error("pump up missing on lag");
    pfd_dn_a: assert property (ce_i && vco_if.tick && !ref_if.tick && !pump_up_pulse_o
        |=> pump_down_pulse_o && !pump_up_pulse_o)
        else $error("pump down missing on lead");
    lock_pin_a: assert property ((lock_indicator_oe_o == !locked && !lock_indicator_o)
        and ($rose(locked) |-> $past(lf) < LF_W'($past(lock_thr))))
        else $error("lock indicator drive wrong");

    bus_load_c: cover property (in_bus && tr_r ##1 bbank_s == 1'b0);
    serial_load_c: cover property (in_serial && sclk_r ##[1:300] sen_r);
    lock_gain_c: cover property ($rose(locked));
    wb_read_c: cover property (req && !wb_we_i && wb_adr_i == `PDP_REG_STATUS);

endmodule // pdp_top

// file: testbench/pdp_host_model.sv
/*
 * Host model: strobed byte writes and three-wire serial loads.
 * Assumes the bench clock; pins change only just after its rise.
 */
`timescale 1ns/1ns
module pdp_host_model (
    input wire logic clk_i,
    output logic [7:0] data_o,
    output logic [3:0] strobe_o,
    output logic shift_data_in_o,
    output logic sen_n_o,
    output logic sclk_o
);
    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    initial begin
        data_o = 8'h00;
        strobe_o = 4'h0;
        shift_data_in_o = 1'b0;
        sen_n_o = 1'b1;
        sclk_o = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // strobe 0 low main, 1 high main, 2 swallow, 3 transfer
    task automatic bus_write(input int s, input logic [7:0] d);
        data_o <= d;
        hold(4);
        strobe_o[s] <= 1'b1;
        hold(8);
        strobe_o[s] <= 1'b0;
        data_o <= ~d;
        hold(4);
    endtask
    // msb first, enable low over the whole frame
    task automatic shift20(input logic [19:0] v);
        sen_n_o <= 1'b0;
        hold(4);
        for (int i = 19; i >= 0; i--) begin
            shift_data_in_o <= v[i];
            hold(8);
            sclk_o <= 1'b1;
            hold(8);
            sclk_o <= 1'b0;
        end
        hold(8);
        sen_n_o <= 1'b1;
        shift_data_in_o <= ~v[0];
        hold(8);
    endtask
endmodule // pdp_host_model

// file: testbench/pdp_top_test.sv
/*
 * Bench of the program interface: registers, three load modes, dividers.
 * Assumes the host model drives the load pins.
 */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module pdp_top_test;
    // ----------------------------------------------------------------
    // stimulus and checks
    // ----------------------------------------------------------------
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00, dbus;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic compat_n = 1, bus_n = 0, ser = 0, bsel = 0, ssel = 0, osc = 0, refc = 0;
    logic [3:0] dsw = 4'h0, dref = 4'h0, stb;
    logic sdat, sen_n, sclk, fb, rdv, pu, pd, lfn, ld, ld_oe;
    logic [1:0] ph = 2'h0;
    int num_errors = 0, n_checks = 0;
    time fb_t = 0, fb_per = 0, rf_t = 0, rf_per = 0;
    always #5 clk_i = ~clk_i;
    pdp_host_model host (.clk_i(clk_i), .data_o(dbus), .strobe_o(stb), .shift_data_in_o(sdat),
        .sen_n_o(sen_n), .sclk_o(sclk));
    pdp_top dut (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .legacy_compat_select_n_i(compat_n),
        .bus_select_n_i(bus_n), .serial_select_i(ser), .host_data_bus_i(dbus),
        .main_low_write_strobe_i(stb[0]), .main_high_write_strobe_i(stb[1]),
        .swallow_write_strobe_i(stb[2]), .transfer_write_strobe_i(stb[3]),
        .bus_bank_select_i(bsel), .serial_bank_select_i(ssel), .shift_data_in_i(sdat),
        .shift_enable_n_i(sen_n), .shift_clk_i(sclk), .direct_swallow_i(dsw),
        .direct_ref_i(dref), .oscillator_input_i(osc), .reference_input_i(refc),
        .feedback_divided_out_o(fb), .reference_divided_out_o(rdv), .pump_up_pulse_o(pu),
        .pump_down_pulse_o(pd), .lock_filter_node_o(lfn), .lock_indicator_o(ld),
        .lock_indicator_oe_o(ld_oe));
    // both inputs: 3 cycles high, 3 low
    always @(posedge clk_i) begin
        ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
        if (ph == 2'h2) begin
            osc <= ~osc;
            refc <= ~refc;
        end
    end
    always @(posedge fb) begin
        fb_per = $time - fb_t;
        fb_t = $time;
    end
    always @(posedge rdv) begin
        rf_per = $time - rf_t;
        rf_t = $time;
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        if (n >= 40) num_errors++;
        if (n >= 40) complete_run();
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic t_regs();
        wb(0, 8'h00, 0); `CHK("cfg", 32'h00001040, q)
        wb(1, 8'h00, 32'h00002233);
        wb(0, 8'h00, 0); `CHK("cfg_wr", 32'h00002233, q)
        wb(0, 8'h40, 0); `CHK("unmapped", 32'h0, q)
    endtask
    task automatic t_bus();
        host.bus_write(0, 8'h85);
        host.bus_write(1, 8'h0F);
        host.bus_write(2, 8'hA6);
        wb(0, 8'h0C, 0); `CHK("primary", 32'h000E17A6, q)
        wb(0, 8'h08, 0); `CHK("act_sec", 32'h0, q)
        bsel <= 1;
        repeat (5) @(posedge clk_i);
        wb(0, 8'h08, 0); `CHK("act_pri", 32'h000E17A6, q)
        compat_n <= 0;
        repeat (5) @(posedge clk_i);
        wb(0, 8'h08, 0); `CHK("compat", 32'h000814A6, q)
        compat_n <= 1;
        host.bus_write(3, 8'h00);
        wb(0, 8'h10, 0); `CHK("secondary", 32'h000E17A6, q)
    endtask
    task automatic t_serial();
        host.bus_write(2, 8'h11);
        ser <= 1;
        repeat (5) @(posedge clk_i);
        wb(0, 8'h08, 0); `CHK("ser_bank0", 32'h000E17A6, q)
        host.bus_write(3, 8'h00);
        wb(0, 8'h10, 0); `CHK("ser_hop", 32'h000E1711, q)
        ssel <= 1;
        host.shift20(20'h5A3C6);
        wb(0, 8'h04, 0); `CHK("mode", 2'b01, q[1:0])
        wb(0, 8'h10, 0); `CHK("ser_sec", 32'h0005A3C6, q)
        wb(0, 8'h08, 0); `CHK("ser_act", 32'h0005A3C6, q)
    endtask
    task automatic t_direct();
        bus_n <= 1;
        host.data_o <= 8'h2B;
        dsw <= 4'hC;
        dref <= 4'h9;
        repeat (10) @(posedge clk_i);
        wb(0, 8'h08, 0); `CHK("direct", 32'h0000AC9C, q)
        host.data_o <= 8'h00;
        dsw <= 4'h3;
        repeat (2000) @(posedge clk_i);
        `CHK("fb_per", 64'd780, fb_per)
        `CHK("ref_per", 64'd600, rf_per)
        `CHK("lock_pin", 2'b10, {ld_oe, ld})
        wb(1, 8'h00, 32'h000000FF);
        repeat (400) @(posedge clk_i);
        `CHK("locked", 2'b00, {ld_oe, ld})
        wb(0, 8'h04, 0); `CHK("lock_st", 1'b1, q[2])
        @(negedge clk_i);
        `CHK("filter", pu | pd, lfn)
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        t_regs();
        t_bus();
        t_serial();
        t_direct();
        complete_run();
    end
    initial begin
        repeat (60000) @(posedge clk_i);
        num_errors++;
        complete_run();
    end
endmodule // pdp_top_test
